// ### verilog/locality_cmd_fifo_ctrl_consts.svh
`ifndef LOCALITY_CMD_FIFO_CTRL_CONSTS_SVH
`define LOCALITY_CMD_FIFO_CTRL_CONSTS_SVH
// Register word offsets inside one locality window; window index is addr[6:4].
`define ACCESS_WORD_OFS     2'h0
`define STATUS_WORD_OFS     2'h1
`define QUEUE_PORT_OFS      2'h2
`define LOC_WINDOW_COUNT    3'h5
`define DIGEST_CTRL_ADDR    7'h50
// Access word field positions.
`define ACC_ESTABLISHED_BIT 0
`define ACC_REQUEST_BIT     1
`define ACC_WAITING_BIT     2
`define ACC_TAKEOVER_BIT    3
`define ACC_LOST_BIT        4
`define ACC_HELD_BIT        5
`define ACC_VALID_BIT       7
// Status word field positions.
`define STS_EXPECT_BIT      3
`define STS_RESP_READY_BIT  4
`define STS_GO_BIT          5
`define STS_CMD_READY_BIT   6
`define STS_BURST_LSB       8
// Digest control word field positions.
`define DIG_BEGIN_BIT       0
`define DIG_END_BIT         1
// Byte queue depth, reset values and the value read from unmapped addresses.
`define QUEUE_DEPTH         64
`define NO_LOCALITY         3'h7
`define ESTABLISHED_RESET   1'b0
`define UNMAPPED_READ       32'hFFFFFFFF
`endif

// ### verilog/locality_cmd_fifo_ctrl_pkg.sv
package locality_cmd_fifo_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READY = 2'b01,
    ST_EXEC  = 2'b10,
    ST_RESP  = 2'b11
  } cmd_state_e;

  typedef logic [5:0] qptr_t;
  typedef logic [6:0] qcount_t;

  // One host write, decoded.
  typedef struct packed {
    logic       valid;
    logic [2:0] loc;
    logic [1:0] ofs;
    logic       digest;
    logic [7:0] data;
  } host_wr_s;

  // Engine response byte.
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } resp_byte_s;
endpackage

// ### verilog/locality_cmd_fifo_ctrl.sv
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
`include "locality_cmd_fifo_ctrl_consts.svh"
module locality_cmd_fifo_ctrl
  import locality_cmd_fifo_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Command engine
  output logic             exec_go,
  output logic             exec_abort,
  output logic [2:0]       exec_locality,
  output logic             cmd_rd_valid,
  output logic [7:0]       cmd_rd_byte,
  input  wire logic        cmd_rd_ready,
  input  wire resp_byte_s  resp_in,
  output logic             resp_ready
);
  cmd_state_e  state, next_state;
  logic [7:0]  queue [`QUEUE_DEPTH];
  qptr_t       wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  qcount_t     count, next_count;
  logic        resp_done, next_resp_done;
  logic [2:0]  active, next_active;
  logic [4:0]  pending, next_pending, seized, next_seized;
  logic        established, next_established;
  logic        digest_busy, next_digest_busy;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [6:0]  aw_addr, next_aw_addr;
  logic [7:0]  w_data, next_w_data;
  logic        w_lane0, next_w_lane0;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic        abort, next_abort;
  logic        push, pop, abort_now, grant_req, seize_ok, release_ok;
  logic        pop_host;
  logic [7:0]  push_byte;
  host_wr_s    hw;
  logic [6:0]  ar_addr;
  logic        ar_take;

  function automatic logic [2:0] top_pending(input logic [4:0] req);
    top_pending = `NO_LOCALITY;
    for (int i = 0; i < 5; i++) begin
      if (req[i]) begin
        top_pending = 3'(i);
      end
    end
  endfunction

  function automatic logic in_window(input logic [6:0] a);
    in_window = (a[6:4] < `LOC_WINDOW_COUNT) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [7:0] access_view(input logic [2:0] loc,
                                             input logic [2:0] act,
                                             input logic [4:0] pend,
                                             input logic [4:0] lost,
                                             input logic       est);
    access_view = 8'h00;
    access_view[`ACC_VALID_BIT] = 1'b1;
    access_view[`ACC_HELD_BIT] = (act == loc);
    access_view[`ACC_LOST_BIT] = lost[loc];
    access_view[`ACC_WAITING_BIT] = |(pend & ~(5'h01 << loc));
    access_view[`ACC_REQUEST_BIT] = pend[loc];
    access_view[`ACC_ESTABLISHED_BIT] = ~est;
  endfunction

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = 2'h0;
  assign exec_go       = (state == ST_EXEC);
  assign exec_abort    = abort;
  assign exec_locality = active;
  assign cmd_rd_valid  = (state == ST_EXEC) && (count != 7'h00) && !resp_done;
  assign cmd_rd_byte   = queue[rd_ptr];
  assign resp_ready    = (state == ST_EXEC) && (count != 7'(`QUEUE_DEPTH));
  assign ar_addr       = s_axi_araddr[6:0];
  assign ar_take       = s_axi_arvalid && !rvalid;

  always_comb begin
    hw.valid  = aw_held && w_held && !bvalid;
    hw.loc    = aw_addr[6:4];
    hw.ofs    = aw_addr[3:2];
    hw.digest = (aw_addr == `DIGEST_CTRL_ADDR);
    hw.data   = w_lane0 ? w_data : 8'h00;
  end

  always_comb begin
    next_state       = state;
    next_resp_done   = resp_done;
    next_active      = active;
    next_pending     = pending;
    next_seized      = seized;
    next_established = established;
    next_digest_busy = digest_busy;
    next_abort       = 1'b0;
    push             = 1'b0;
    pop              = 1'b0;
    pop_host         = 1'b0;
    push_byte        = 8'h00;
    abort_now        = 1'b0;
    grant_req        = 1'b0;
    seize_ok         = 1'b0;
    release_ok       = 1'b0;
    // Bus channel capture; address and data may arrive in either order.
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = bvalid && !s_axi_bready;
    next_rvalid  = rvalid && !s_axi_rready;
    next_rdata   = rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[6:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_data  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (hw.valid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
    end
    // Host writes to the access word; set request, takeover, lost and held bits act, all other bits do nothing.
    if (hw.valid && in_window(aw_addr) && hw.ofs == `ACCESS_WORD_OFS) begin
      if (hw.data[`ACC_LOST_BIT]) begin
        next_seized[hw.loc] = 1'b0;
      end
      // Release, then takeover, then request: several bits in one write all act.
      if (hw.data[`ACC_HELD_BIT] && active == hw.loc) begin
        release_ok   = 1'b1;
        abort_now    = 1'b1;
        next_active  = top_pending(pending);
        if (next_active != `NO_LOCALITY) begin
          next_pending[next_active] = 1'b0;
        end
      end
      if (hw.data[`ACC_TAKEOVER_BIT] &&
          (next_active == `NO_LOCALITY || hw.loc > next_active)) begin
        seize_ok = 1'b1;
        if (next_active != `NO_LOCALITY) begin
          next_seized[next_active] = 1'b1;
        end
        next_active           = hw.loc;
        next_pending[hw.loc]  = 1'b0;
        abort_now             = 1'b1;
      end
      if (hw.data[`ACC_REQUEST_BIT] && next_active != hw.loc) begin
        if (next_active == `NO_LOCALITY) begin
          grant_req   = 1'b1;
          next_active = hw.loc;
        end else begin
          next_pending[hw.loc] = 1'b1;
        end
      end
    end
    // Digest sequence control, honoured whenever no locality is active.
    if (hw.valid && hw.digest && active == `NO_LOCALITY) begin
      if (hw.data[`DIG_BEGIN_BIT]) begin
        next_digest_busy = 1'b1;
        next_established = 1'b1;
        abort_now        = 1'b1;
      end
      if (hw.data[`DIG_END_BIT]) begin
        next_digest_busy = 1'b0;
      end
    end
    // Status word and byte queue of the active locality.
    if (hw.valid && in_window(aw_addr) && hw.loc == active) begin
      if (hw.ofs == `STATUS_WORD_OFS && hw.data[`STS_CMD_READY_BIT]) begin
        case (state)
          ST_IDLE: begin
            next_state = ST_READY;
          end
          ST_READY: begin
            if (count != 7'h00) begin
              abort_now = 1'b1;
            end
          end
          ST_EXEC, ST_RESP: begin
            abort_now = 1'b1;
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end
      if (hw.ofs == `STATUS_WORD_OFS && hw.data[`STS_GO_BIT] &&
          state == ST_READY && count != 7'h00) begin
        next_state     = ST_EXEC;
        next_resp_done = 1'b0;
      end
      if (hw.ofs == `QUEUE_PORT_OFS && state == ST_READY &&
          count != 7'(`QUEUE_DEPTH)) begin
        push      = 1'b1;
        push_byte = hw.data;
      end
    end
    // Engine side: command bytes out, response bytes in.
    if (cmd_rd_valid && cmd_rd_ready) begin
      pop = 1'b1;
    end
    if (resp_in.valid && resp_ready) begin
      push           = 1'b1;
      push_byte      = resp_in.data;
      next_resp_done = 1'b1;
      if (resp_in.last) begin
        next_state = ST_RESP;
      end
    end
    // Host read of the byte queue pops one response byte.
    if (ar_take && in_window(ar_addr) && ar_addr[6:4] == active &&
        ar_addr[3:2] == `QUEUE_PORT_OFS && state == ST_RESP && count != 7'h00) begin
      pop      = 1'b1;
      pop_host = 1'b1;
      if (count == 7'h01) begin
        next_state = ST_IDLE;
      end
    end
    next_wr_ptr = wr_ptr + 6'(push);
    next_rd_ptr = rd_ptr + 6'(pop);
    next_count = count + 7'(push) - 7'(pop);
    // Abort drops everything queued, so no partial response survives.
    if (abort_now) begin
      next_state     = ST_IDLE;
      next_wr_ptr    = 6'h00;
      next_rd_ptr    = 6'h00;
      next_count     = 7'h00;
      next_resp_done = 1'b0;
      next_abort     = (state == ST_EXEC);
    end
    // Read data selection.
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rdata  = `UNMAPPED_READ;
      if (ar_addr == `DIGEST_CTRL_ADDR) begin
        next_rdata = {31'h00000000, digest_busy};
      end else if (in_window(ar_addr) && ar_addr[3:2] == `ACCESS_WORD_OFS) begin
        next_rdata = {24'h000000,
                      access_view(ar_addr[6:4], active, pending, seized, established)};
      end else if (in_window(ar_addr) && ar_addr[6:4] == active &&
                   ar_addr[3:2] == `STATUS_WORD_OFS) begin
        next_rdata = 32'h00000000;
        next_rdata[`STS_CMD_READY_BIT] = (state == ST_READY) && (count == 7'h00);
        next_rdata[`STS_EXPECT_BIT] = (state == ST_READY);
        next_rdata[`STS_RESP_READY_BIT] = (state == ST_RESP) && (count != 7'h00);
        // Free room while receiving, bytes held while answering.
        if (state == ST_READY) begin
          next_rdata[`STS_BURST_LSB +: 8] = 8'(7'(`QUEUE_DEPTH) - count);
        end else if (state == ST_RESP) begin
          next_rdata[`STS_BURST_LSB +: 8] = 8'(count);
        end
      end else if (pop_host) begin
        next_rdata = {24'h000000, queue[rd_ptr]};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= ST_IDLE;
      wr_ptr      <= 6'h00;
      rd_ptr      <= 6'h00;
      count       <= 7'h00;
      resp_done   <= 1'b0;
      active      <= `NO_LOCALITY;
      pending     <= 5'h00;
      seized      <= 5'h00;
      established <= `ESTABLISHED_RESET;
      digest_busy <= 1'b0;
      aw_held     <= 1'b0;
      aw_addr     <= 7'h00;
      w_held      <= 1'b0;
      w_data      <= 8'h00;
      w_lane0     <= 1'b0;
      bvalid      <= 1'b0;
      rvalid      <= 1'b0;
      rdata       <= 32'h00000000;
      abort       <= 1'b0;
    end else begin
      state       <= next_state;
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      resp_done   <= next_resp_done;
      active      <= next_active;
      pending     <= next_pending;
      seized      <= next_seized;
      established <= next_established;
      digest_busy <= next_digest_busy;
      aw_held     <= next_aw_held;
      aw_addr     <= next_aw_addr;
      w_held      <= next_w_held;
      w_data      <= next_w_data;
      w_lane0     <= next_w_lane0;
      bvalid      <= next_bvalid;
      rvalid      <= next_rvalid;
      rdata       <= next_rdata;
      abort       <= next_abort;
    end
  end

  // Queue storage carries no reset; only pointers define content.
  always_ff @(posedge aclk) begin
    if (push && !abort_now) begin
      queue[wr_ptr] <= push_byte;
    end
  end

  sequence s_write_pair;
    hw.valid;
  endsequence
  sequence s_answer;
    ##1 bvalid;
  endsequence

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_pair |-> s_answer) else $error("write response missing");
  a_abort_flush: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_now |=> (state == ST_IDLE) && (count == 7'h00)) else $error("abort left data");
  a_flag_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (pop_host && count == 7'h01 && !abort_now) |=> state == ST_IDLE)
    else $error("response flag stays after last byte");
  a_resp_enter: assert property (@(posedge aclk) disable iff (!aresetn)
    (resp_in.valid && resp_in.last && resp_ready && !abort_now) |=>
    (state == ST_RESP) && (count != 7'h00)) else $error("no response ready");
  a_grant_free: assert property (@(posedge aclk) disable iff (!aresetn)
    grant_req |=> active == $past(hw.loc)) else $error("free grant failed");
  a_pending_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (hw.valid && in_window(aw_addr) && hw.ofs == `ACCESS_WORD_OFS &&
     hw.data == 8'h02 && active != `NO_LOCALITY && active != hw.loc) |=>
    pending[$past(hw.loc)] && $stable(active)) else $error("request not held pending");
  a_release_next: assert property (@(posedge aclk) disable iff (!aresetn)
    (release_ok && !seize_ok && !grant_req && pending == 5'h00) |=>
    active == `NO_LOCALITY) else $error("release did not free");
  a_seize_mark: assert property (@(posedge aclk) disable iff (!aresetn)
    (seize_ok && !release_ok && active != `NO_LOCALITY) |=>
    seized[$past(active)] && active == $past(hw.loc)) else $error("takeover not marked");
  a_abort_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    (abort_now && state == ST_EXEC) |=> exec_abort ##1 !exec_abort)
    else $error("engine abort not one pulse");
endmodule // locality_cmd_fifo_ctrl

// ### testbench/cmd_engine_model.sv
`timescale 1ns/100ps
module cmd_engine_model
  import locality_cmd_fifo_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Controller side
  input  wire logic       exec_go,
  input  wire logic       cmd_rd_valid,
  input  wire logic [7:0] cmd_rd_byte,
  output logic            cmd_rd_ready,
  output resp_byte_s      resp_in,
  input  wire logic       resp_ready,
  // Bench controls
  input  wire logic       hold,
  input  wire logic [3:0] n_resp,
  input  wire logic [7:0] resp_base,
  output logic [3:0]      n_popped,
  output logic [7:0]      last_cmd
);
  logic [3:0] sent;
  logic       push;

  assign cmd_rd_ready = exec_go && !hold;
  assign push = exec_go && !hold && !cmd_rd_valid && (sent < n_resp);
  // Response bytes are offered only after the whole command has been drained.
  assign resp_in = {push, push && (sent == n_resp - 4'h1),
                    push ? resp_base + {4'h0, sent} : ~(resp_base + {4'h0, sent})};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sent <= 4'h0;
      n_popped <= 4'h0;
      last_cmd <= 8'h00;
    end else begin
      if (cmd_rd_valid && cmd_rd_ready) begin
        n_popped <= n_popped + 4'h1;
        last_cmd <= cmd_rd_byte;
      end
      if (!exec_go) sent <= 4'h0;
      else if (push && resp_ready) sent <= sent + 4'h1;
    end
  end
endmodule // cmd_engine_model

// ### testbench/locality_cmd_fifo_ctrl_bench.sv
`timescale 1ns/100ps
module locality_cmd_fifo_ctrl_bench
  import locality_cmd_fifo_ctrl_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hold;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        exec_go, exec_abort, cmd_rd_valid, cmd_rd_ready, resp_ready;
  logic [2:0]  exec_locality;
  logic [7:0]  cmd_rd_byte, last_cmd;
  logic [3:0]  n_popped;
  resp_byte_s  resp_in;
  int          n_fail, n_tests, n_abort;

  locality_cmd_fifo_ctrl locality_cmd_fifo_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .exec_go(exec_go), .exec_abort(exec_abort), .exec_locality(exec_locality),
    .cmd_rd_valid(cmd_rd_valid), .cmd_rd_byte(cmd_rd_byte), .cmd_rd_ready(cmd_rd_ready),
    .resp_in(resp_in), .resp_ready(resp_ready));

  cmd_engine_model cmd_engine_model_inst (
    .aclk(aclk), .aresetn(aresetn), .exec_go(exec_go), .cmd_rd_valid(cmd_rd_valid),
    .cmd_rd_byte(cmd_rd_byte), .cmd_rd_ready(cmd_rd_ready), .resp_in(resp_in),
    .resp_ready(resp_ready), .hold(hold), .n_resp(4'h2), .resp_base(8'hC3),
    .n_popped(n_popped), .last_cmd(last_cmd));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Counted mid-cycle so a check right after a write never races the count.
  always @(negedge aclk) if (exec_abort === 1'b1) n_abort++;

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timed_out();
    n_fail++;
    $display("[FAIL] handshake expected response seen none");
    give_verdict();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 40) timed_out();
    bready <= 1'b0;
    check32("bresp", 32'h0, {30'h0, bresp});
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    int i;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 40) timed_out();
    d = rdata;
    rready <= 1'b0;
    check32("rresp", 32'h0, {30'h0, rresp});
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check32(what, exp, d);
  endtask

  // Polls a status word until response-ready and a nonzero burst depth appear.
  task automatic wait_resp(input logic [31:0] a);
    logic [31:0] d;
    int i;
    for (i = 0; i < 50; i++) begin
      rd(a, d);
      if (d[4] === 1'b1 && d[15:8] !== 8'h00) break;
    end
    if (i == 50) timed_out();
  endtask

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; hold = 1'b0; awaddr = 32'h0; wdata = 32'h0; araddr = 32'h0;
    n_fail = 0; n_tests = 0; n_abort = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("access0 reset", 32'h00, 32'h81);
    wr(32'h00, 32'h02);
    rd_chk("access0 held", 32'h00, 32'hA1);
    wr(32'h10, 32'h02);
    wr(32'h20, 32'h02);
    rd_chk("access1 pending", 32'h10, 32'h87);
    rd_chk("access0 waiting", 32'h00, 32'hA5);
    wr(32'h00, 32'h20);
    rd_chk("access2 granted", 32'h20, 32'hA5);
    check32("exec locality", 32'h2, {29'h0, exec_locality});
    rd_chk("access0 released", 32'h00, 32'h85);
    wr(32'h20, 32'h00);
    rd_chk("access2 zero write", 32'h20, 32'hA5);
    rd_chk("status0 inactive", 32'h04, 32'hFFFFFFFF);
    wr(32'h24, 32'h40);
    rd_chk("status ready", 32'h24, 32'h4048);
    wr(32'h28, 32'h11);
    wr(32'h28, 32'h22);
    wr(32'h28, 32'h33);
    rd_chk("status receiving", 32'h24, 32'h3D08);
    wr(32'h24, 32'h20);
    wait_resp(32'h24);
    rd_chk("status response", 32'h24, 32'h0210);
    check32("bytes popped", 32'h3, {28'h0, n_popped});
    check32("last command byte", 32'h33, {24'h0, last_cmd});
    rd_chk("response byte 0", 32'h28, 32'hC3);
    rd_chk("status one left", 32'h24, 32'h0110);
    rd_chk("response byte 1", 32'h28, 32'hC4);
    rd_chk("status drained", 32'h24, 32'h0000);
    wr(32'h24, 32'h40);
    wr(32'h28, 32'h88);
    wr(32'h24, 32'h20);
    wait_resp(32'h24);
    wr(32'h24, 32'h40);
    rd_chk("status response abort", 32'h24, 32'h0000);
    check32("last command byte 2", 32'h88, {24'h0, last_cmd});
    hold <= 1'b1;
    wr(32'h24, 32'h40);
    wr(32'h28, 32'h44);
    wr(32'h24, 32'h20);
    wr(32'h24, 32'h40);
    check32("abort count exec", 32'h1, n_abort);
    rd_chk("status after abort", 32'h24, 32'h0000);
    wr(32'h24, 32'h40);
    wr(32'h28, 32'h55);
    wr(32'h24, 32'h40);
    rd_chk("status receive abort", 32'h24, 32'h0000);
    wr(32'h24, 32'h40);
    rd_chk("queue flushed", 32'h24, 32'h4048);
    wr(32'h28, 32'h66);
    wr(32'h10, 32'h08);
    rd_chk("refused takeover", 32'h24, 32'h3F08);
    wr(32'h24, 32'h20);
    wr(32'h30, 32'h08);
    check32("abort count takeover", 32'h2, n_abort);
    rd_chk("access3 took over", 32'h30, 32'hA5);
    rd_chk("access2 lost", 32'h20, 32'h95);
    wr(32'h20, 32'h10);
    rd_chk("access2 lost cleared", 32'h20, 32'h85);
    wr(32'h34, 32'h40);
    wr(32'h38, 32'h77);
    wr(32'h34, 32'h20);
    wr(32'h30, 32'h20);
    check32("abort count release", 32'h3, n_abort);
    rd_chk("access1 granted", 32'h10, 32'hA1);
    rd_chk("status3 inactive", 32'h34, 32'hFFFFFFFF);
    hold <= 1'b0;
    wr(32'h10, 32'h20);
    rd_chk("device free", 32'h00, 32'h81);
    wr(32'h50, 32'h01);
    rd_chk("digest busy", 32'h50, 32'h1);
    rd_chk("established shown", 32'h00, 32'h80);
    wr(32'h50, 32'h02);
    rd_chk("digest done", 32'h50, 32'h0);
    wr(32'h60, 32'h12);
    rd_chk("unmapped", 32'h60, 32'hFFFFFFFF);
    check32("bytes popped end", 32'h4, {28'h0, n_popped});
    give_verdict();
  end
endmodule // locality_cmd_fifo_ctrl_bench
